/* rtl/fswp_cfg.svh */
/*
  Constants for the flash section write protection block: lock field positions,
  reset values and pointer layout.
  Assumes inclusion by bare name from rtl/ files only.
*/
`ifndef FSWP_CFG_SVH
`define FSWP_CFG_SVH

// lock byte layout, as seen on lock read and write data
`define FSWP_LB_GEN_LO    0
`define FSWP_LB_GEN_HI    1
`define FSWP_LB_APP_LO    2
`define FSWP_LB_APP_HI    3
`define FSWP_LB_BOOT_LO   4
`define FSWP_LB_BOOT_HI   5
`define FSWP_LOCK_ERASED  8'hff
`define FSWP_FUSE_ERASED  1'b1

`define FSWP_APP_RESET_W  16'h0000
`define FSWP_SMALL_SPACE  32'h0001_0000
`define FSWP_PTR_W        24
`define FSWP_BLOCKED_BYTE 8'h00

`endif

/* rtl/fswp_pkg.sv */
/*
  Types shared by the protection block files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fswp_pkg;

  typedef enum logic [2:0] {
    FSWP_CMD_FILL,
    FSWP_CMD_ERASE,
    FSWP_CMD_WRITE,
    FSWP_CMD_LOCK,
    FSWP_CMD_FUSE
  } fswp_cmd_t;

  typedef enum logic [1:0] {
    FSWP_PROT_OPEN,
    FSWP_PROT_NO_STORE,
    FSWP_PROT_NO_BOTH,
    FSWP_PROT_NO_LOAD
  } fswp_prot_t;

endpackage : fswp_pkg

/* rtl/fswp_lock_store.sv */
/*
  Nonvolatile-style holder for lock bits and the reset vector fuse.
  Assumes single clock, synchronous active high reset, one writer per cycle.
*/
`timescale 1ns/1ps
`include "fswp_cfg.svh"

module fswp_lock_store (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       sw_lock_wr_i,
  input  wire logic [7:0] sw_lock_data_i,
  input  wire logic       prog_lock_wr_i,
  input  wire logic [7:0] prog_lock_data_i,
  input  wire logic       prog_fuse_wr_i,
  input  wire logic       prog_fuse_data_i,
  input  wire logic       chip_erase_i,
  output logic      [7:0] lock_q_o,
  output logic            fuse_q_o
);
  import fswp_pkg::*;

  logic [7:0] lock_q;
  logic [7:0] lock_d;
  logic       fuse_q;
  logic       fuse_d;

  // lock programming only clears bits and erase alone sets them; the fuse takes any written value and keeps it through erase
  assign lock_d = chip_erase_i   ? `FSWP_LOCK_ERASED :
                  prog_lock_wr_i ? (lock_q & prog_lock_data_i) :
                  sw_lock_wr_i   ? (lock_q & (sw_lock_data_i | 8'hc0)) : lock_q;
  assign fuse_d = chip_erase_i   ? fuse_q :
                  prog_fuse_wr_i ? prog_fuse_data_i : fuse_q;

  // reset stands in for a blank part; real storage would not reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock_q <= `FSWP_LOCK_ERASED;
      fuse_q <= `FSWP_FUSE_ERASED;
    end else begin
      lock_q <= lock_d;
      fuse_q <= fuse_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock_q_o <= `FSWP_LOCK_ERASED;
      fuse_q_o <= `FSWP_FUSE_ERASED;
    end else begin
      lock_q_o <= lock_d;
      fuse_q_o <= fuse_d;
    end
  end

endmodule : fswp_lock_store

/* rtl/fswp_top.sv */
/*
  Flash section protection and pointer logic for self-programming.
  Assumes the core presents one store or load request at a time, synchronous
  to clk_sys_i, and that the flash array accepts a command pulse each cycle.
*/
`timescale 1ns/1ps
`include "fswp_cfg.svh"

module fswp_top #(
  parameter int PROG_BYTES   = 65536,
  parameter int PAGE_WORDS   = 128,
  parameter int BOOT_START_W = 16'h7000
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // pointer register writes from the core
  input  wire logic              ptr_ext_wr_i,
  input  wire logic              ptr_hi_wr_i,
  input  wire logic              ptr_lo_wr_i,
  input  wire logic [7:0]        ptr_wdata_i,
  output logic      [7:0]        ptr_ext_o,
  output logic      [7:0]        ptr_hi_o,
  output logic      [7:0]        ptr_lo_o,
  // executing context
  input  wire logic [23:0]       exec_pc_i,
  input  wire logic              ivec_in_boot_i,
  output logic                   irq_mask_o,
  // program store instruction
  input  wire logic              store_req_i,
  input  wire fswp_pkg::fswp_cmd_t store_cmd_i,
  input  wire logic [15:0]       store_data_i,
  output logic                   store_go_o,
  output logic                   store_refused_o,
  output fswp_pkg::fswp_cmd_t    flash_cmd_o,
  output logic      [15:0]       flash_page_o,
  output logic      [7:0]        flash_word_o,
  output logic      [15:0]       flash_wdata_o,
  // program load instruction
  input  wire logic              load_req_i,
  output logic                   load_busy_o,
  output logic                   flash_rd_o,
  output logic      [22:0]       flash_raddr_o,
  input  wire logic [15:0]       flash_rdata_i,
  output logic                   load_valid_o,
  output logic                   load_blocked_o,
  output logic      [7:0]        load_data_o,
  // external programmer
  input  wire logic              prog_lock_wr_i,
  input  wire logic [7:0]        prog_lock_data_i,
  input  wire logic              prog_fuse_wr_i,
  input  wire logic              prog_fuse_data_i,
  input  wire logic              chip_erase_i,
  // status
  output logic      [7:0]        lock_bits_o,
  output logic      [15:0]       reset_addr_o,
  output fswp_pkg::fswp_prot_t   app_protection_mode_o,
  output fswp_pkg::fswp_prot_t   boot_protection_mode_o
);
  import fswp_pkg::*;

  localparam int  WORD_BITS = $clog2(PAGE_WORDS);
  localparam bit  HAS_EXT   = (PROG_BYTES > `FSWP_SMALL_SPACE);

  // refused while elaborating, so a bad size never reaches the logic
  if (PAGE_WORDS < 2 || PAGE_WORDS > 256 || (1 << WORD_BITS) != PAGE_WORDS) begin : g_bad_page
    $error("PAGE_WORDS must be a power of two from 2 to 256");
  end
  if (BOOT_START_W < 1 || BOOT_START_W > 16'hffff) begin : g_bad_boot
    $error("BOOT_START_W must fit 16 bits and be nonzero");
  end
  if (2 * BOOT_START_W >= PROG_BYTES) begin : g_bad_space
    $error("BOOT_START_W must lie inside the program space");
  end

  // ********************************************************************
  // decoding helpers
  // ********************************************************************
  function automatic fswp_prot_t mode_of(input logic hi, input logic lo);
    case ({hi, lo})
      2'b11:   mode_of = FSWP_PROT_OPEN;
      2'b10:   mode_of = FSWP_PROT_NO_STORE;
      2'b00:   mode_of = FSWP_PROT_NO_BOTH;
      default: mode_of = FSWP_PROT_NO_LOAD;
    endcase
  endfunction : mode_of

  function automatic logic in_boot(input logic [23:0] word_addr);
    in_boot = (word_addr >= 24'(BOOT_START_W));
  endfunction : in_boot

  // one decode per mode family, shared by both sections
  function automatic logic no_store(input fswp_prot_t mode);
    no_store = (mode == FSWP_PROT_NO_STORE) || (mode == FSWP_PROT_NO_BOTH);
  endfunction : no_store

  function automatic logic no_load(input fswp_prot_t mode);
    no_load = (mode == FSWP_PROT_NO_BOTH) || (mode == FSWP_PROT_NO_LOAD);
  endfunction : no_load

  // ********************************************************************
  // pointer registers
  // ********************************************************************
  logic [7:0]  ext_q;
  logic [7:0]  hi_q;
  logic [7:0]  lo_q;
  logic [7:0]  ext_d;
  logic [7:0]  hi_d;
  logic [7:0]  lo_d;
  logic [23:0] ptr;

  // the extension is tied off on small parts so it reads back zero
  assign ext_d = (HAS_EXT && ptr_ext_wr_i) ? ptr_wdata_i : ext_q;
  assign hi_d  = ptr_hi_wr_i ? ptr_wdata_i : hi_q;
  assign lo_d  = ptr_lo_wr_i ? ptr_wdata_i : lo_q;
  assign ptr   = {ext_q, hi_q, lo_q};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_q <= 8'h00;
      hi_q  <= 8'h00;
      lo_q  <= 8'h00;
    end else begin
      ext_q <= ext_d;
      hi_q  <= hi_d;
      lo_q  <= lo_d;
    end
  end

  assign ptr_ext_o = ext_q;
  assign ptr_hi_o  = hi_q;
  assign ptr_lo_o  = lo_q;

  // ********************************************************************
  // lock and fuse storage
  // ********************************************************************
  logic [7:0] lock_q;
  logic       fuse_q;
  logic       sw_lock_wr;

  fswp_lock_store u_lock (
    .clk_sys_i        (clk_sys_i),
    .rst_i            (rst_i),
    .sw_lock_wr_i     (sw_lock_wr),
    .sw_lock_data_i   (store_data_i[7:0]),
    .prog_lock_wr_i   (prog_lock_wr_i),
    .prog_lock_data_i (prog_lock_data_i),
    .prog_fuse_wr_i   (prog_fuse_wr_i),
    .prog_fuse_data_i (prog_fuse_data_i),
    .chip_erase_i     (chip_erase_i),
    .lock_q_o         (lock_q),
    .fuse_q_o         (fuse_q)
  );

  assign lock_bits_o = lock_q;

  // ********************************************************************
  // section protection decode
  // ********************************************************************
  fswp_prot_t app_mode;
  fswp_prot_t boot_mode;
  logic       exec_boot;
  logic       tgt_boot;
  logic       ld_tgt_boot;
  logic       app_no_store;
  logic       boot_no_store;
  logic       app_no_load;
  logic       boot_no_load;
  logic [15:0] rst_addr_d;
  logic [15:0] rst_addr_q;
  fswp_prot_t  app_mode_q;
  fswp_prot_t  boot_mode_q;

  assign app_mode  = mode_of(lock_q[`FSWP_LB_APP_HI], lock_q[`FSWP_LB_APP_LO]);
  assign boot_mode = mode_of(lock_q[`FSWP_LB_BOOT_HI], lock_q[`FSWP_LB_BOOT_LO]);
  assign app_protection_mode_o  = app_mode_q;
  assign boot_protection_mode_o = boot_mode_q;

  // the general lock bits are deliberately left out of every term below
  assign app_no_store  = no_store(app_mode);
  assign boot_no_store = no_store(boot_mode);
  assign app_no_load   = no_load(app_mode);
  assign boot_no_load  = no_load(boot_mode);

  assign exec_boot   = in_boot(exec_pc_i);
  assign tgt_boot    = in_boot({1'b0, ptr[23:1]});
  assign ld_tgt_boot = tgt_boot;

  // vectors outside the protected section would otherwise fetch across the lock
  assign irq_mask_o = (app_no_load && ivec_in_boot_i && !exec_boot) ||
                      (boot_no_load && !ivec_in_boot_i && exec_boot);

  // reset vector selection
  assign rst_addr_d   = fuse_q ? `FSWP_APP_RESET_W : 16'(BOOT_START_W);
  assign reset_addr_o = rst_addr_q;

  // status outputs from flops; a lock or fuse write shows two cycles later
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_addr_q  <= `FSWP_APP_RESET_W;
      app_mode_q  <= FSWP_PROT_OPEN;
      boot_mode_q <= FSWP_PROT_OPEN;
    end else begin
      rst_addr_q  <= rst_addr_d;
      app_mode_q  <= app_mode;
      boot_mode_q <= boot_mode;
    end
  end

  // ********************************************************************
  // store path
  // ********************************************************************
  logic store_sec_ok;
  logic store_ok;
  logic store_flash;
  logic go_q;
  logic refuse_q;
  fswp_cmd_t cmd_q;
  logic [15:0] page_q;
  logic [7:0]  word_q;
  logic [15:0] wdata_q;
  logic [15:0] page_d;
  logic [7:0]  word_d;

  assign store_flash  = (store_cmd_i == FSWP_CMD_FILL) ||
                        (store_cmd_i == FSWP_CMD_ERASE) ||
                        (store_cmd_i == FSWP_CMD_WRITE);
  assign store_sec_ok = tgt_boot ? !boot_no_store : !app_no_store;
  // fuse commands from the core never reach the storage
  assign store_ok     = store_req_i && exec_boot &&
                        (store_cmd_i != FSWP_CMD_FUSE) &&
                        (!store_flash || store_sec_ok);
  assign sw_lock_wr   = store_ok && (store_cmd_i == FSWP_CMD_LOCK);

  assign word_d = 8'(ptr[WORD_BITS:1]);
  assign page_d = 16'(ptr[23:WORD_BITS+1]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      go_q     <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      go_q     <= store_ok && store_flash;
      refuse_q <= store_req_i && !store_ok;
    end
  end

  // address frozen at start so the core may reuse the pointer at once
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_q   <= FSWP_CMD_FILL;
      page_q  <= 16'h0000;
      word_q  <= 8'h00;
      wdata_q <= 16'h0000;
    end else if (store_ok && store_flash) begin
      cmd_q   <= store_cmd_i;
      page_q  <= page_d;
      word_q  <= word_d;
      wdata_q <= store_data_i;
    end
  end

  assign store_go_o      = go_q;
  assign store_refused_o = refuse_q;
  assign flash_cmd_o     = cmd_q;
  assign flash_page_o    = page_q;
  assign flash_word_o    = word_q;
  assign flash_wdata_o   = wdata_q;

  // ********************************************************************
  // load path
  // ********************************************************************
  typedef enum logic [1:0] {
    FSWP_LD_IDLE,
    FSWP_LD_READ,
    FSWP_LD_DONE
  } fswp_ld_st_t;

  fswp_ld_st_t ld_q;
  fswp_ld_st_t ld_d;
  logic        ld_block;
  logic        ld_take;
  logic        blk_q;
  logic        bsel_q;
  logic [22:0] raddr_q;
  logic [7:0]  data_q;
  logic [7:0]  data_d;
  logic        valid_q;

  // only cross-section reads are fenced; same-section reads stay open
  assign ld_block = ld_tgt_boot ? (boot_no_load && !exec_boot)
                                : (app_no_load && exec_boot);
  assign ld_take  = load_req_i && (ld_q == FSWP_LD_IDLE);

  always_comb begin
    ld_d = ld_q;
    case (ld_q)
      FSWP_LD_IDLE: if (load_req_i) ld_d = FSWP_LD_READ;
      FSWP_LD_READ: ld_d = FSWP_LD_DONE;
      FSWP_LD_DONE: ld_d = FSWP_LD_IDLE;
      default:      ld_d = FSWP_LD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ld_q <= FSWP_LD_IDLE;
    end else begin
      ld_q <= ld_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      blk_q   <= 1'b0;
      bsel_q  <= 1'b0;
      raddr_q <= 23'h000000;
    end else if (ld_take) begin
      blk_q   <= ld_block;
      bsel_q  <= ptr[0];
      raddr_q <= ptr[23:1];
    end
  end

  // blocked reads never sample the array, so nothing protected leaks
  assign data_d = blk_q  ? `FSWP_BLOCKED_BYTE :
                  bsel_q ? flash_rdata_i[15:8] : flash_rdata_i[7:0];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_q  <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      valid_q <= (ld_q == FSWP_LD_READ);
      if (ld_q == FSWP_LD_READ) begin
        data_q <= data_d;
      end
    end
  end

  assign flash_rd_o     = (ld_q == FSWP_LD_READ) && !blk_q;
  assign flash_raddr_o  = raddr_q;
  assign load_busy_o    = (ld_q != FSWP_LD_IDLE);
  assign load_valid_o   = valid_q;
  assign load_blocked_o = valid_q && blk_q;
  assign load_data_o    = data_q;

endmodule : fswp_top

/* bench/fswp_flash_model.sv */
/*
  Behavioural flash array for the protection block's load path.
  Assumes reads are strobed by flash_rd_i and answered in the same cycle.
*/
`timescale 1ns/1ps
module fswp_flash_model (
  input  wire logic        clk_sys_i,
  input  wire logic        flash_rd_i,
  input  wire logic [22:0] flash_raddr_i,
  output logic      [15:0] flash_rdata_o
);
  // ****************************************
  // array contents
  // ****************************************
  // outside a read the bus toggles, so stale data is never mistaken for a hit
  logic [15:0] noise_q = 16'h3c3c;

  always_ff @(posedge clk_sys_i) begin
    noise_q <= ~noise_q ^ 16'h0f0f;
  end

  assign flash_rdata_o = flash_rd_i ? {flash_raddr_i[7:0] ^ 8'ha5, flash_raddr_i[7:0]} : noise_q;
endmodule : fswp_flash_model

/* bench/fswp_monitor.sv */
/*
  Port checker for fswp_top.
  Assumes binding into fswp_top with its parameters handed on.
*/
`timescale 1ns/1ps
module fswp_monitor #(
  parameter int PROG_BYTES   = 65536,
  parameter int PAGE_WORDS   = 128,
  parameter int BOOT_START_W = 16'h7000
) (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic [7:0]          ptr_ext_o,
  input wire logic [7:0]          ptr_hi_o,
  input wire logic [7:0]          ptr_lo_o,
  input wire logic [23:0]         exec_pc_i,
  input wire logic                ivec_in_boot_i,
  input wire logic                irq_mask_o,
  input wire logic                store_req_i,
  input wire fswp_pkg::fswp_cmd_t store_cmd_i,
  input wire logic                store_go_o,
  input wire logic                store_refused_o,
  input wire logic [15:0]         flash_page_o,
  input wire logic [7:0]          flash_word_o,
  input wire logic                load_req_i,
  input wire logic                load_busy_o,
  input wire logic                flash_rd_o,
  input wire logic [22:0]         flash_raddr_o,
  input wire logic [15:0]         flash_rdata_i,
  input wire logic                load_valid_o,
  input wire logic                load_blocked_o,
  input wire logic [7:0]          load_data_o,
  input wire logic                chip_erase_i,
  input wire logic [7:0]          lock_bits_o
);
  import fswp_pkg::*;
  localparam int W = $clog2(PAGE_WORDS);
  logic [23:0] ptr;
  logic        ex_boot, tg_boot, ld_take, ld_blk, st_flash;

  assign ptr      = {ptr_ext_o, ptr_hi_o, ptr_lo_o};
  assign ex_boot  = exec_pc_i >= 24'(BOOT_START_W);
  assign tg_boot  = (ptr >> 1) >= 24'(BOOT_START_W);
  assign ld_take  = load_req_i && !load_busy_o;
  assign ld_blk   = (!tg_boot && ex_boot && !lock_bits_o[3]) || (tg_boot && !ex_boot && !lock_bits_o[5]);
  assign st_flash = store_req_i && ex_boot && store_cmd_i inside {FSWP_CMD_FILL, FSWP_CMD_ERASE, FSWP_CMD_WRITE};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_APP_REFUSE: assert property (store_req_i && !ex_boot |=> store_refused_o && !store_go_o)
    else $error("store from application section not refused");
  AST_FUSE_REFUSE: assert property (store_req_i && store_cmd_i == FSWP_CMD_FUSE |=> store_refused_o)
    else $error("fuse store not refused");
  AST_APP_STORE_LOCK: assert property (st_flash && !tg_boot && !lock_bits_o[2] |=> store_refused_o && !store_go_o)
    else $error("store to locked application section issued");
  AST_BOOT_STORE_LOCK: assert property (st_flash && tg_boot && !lock_bits_o[4] |=> store_refused_o && !store_go_o)
    else $error("store to locked loader section issued");
  AST_STORE_GO: assert property (st_flash && (tg_boot ? lock_bits_o[4] : lock_bits_o[2]) |=>
      store_go_o && flash_page_o == 16'($past(ptr) >> (W + 1))
      && flash_word_o == 8'(($past(ptr) >> 1) & (PAGE_WORDS - 1)))
    else $error("open store not issued with split address");
  AST_LOAD_BLOCK: assert property (ld_take && ld_blk |-> ##1 !flash_rd_o ##1
      (load_valid_o && load_blocked_o && load_data_o == 8'h00))
    else $error("protected load not blocked");
  AST_LOAD_DATA: assert property (ld_take && !ld_blk |-> ##1
      (flash_rd_o && flash_raddr_o == 23'($past(ptr) >> 1))
      ##1 (load_valid_o && !load_blocked_o && load_data_o == ($past(ptr_lo_o[0], 2) ? $past(flash_rdata_i[15:8])
      : $past(flash_rdata_i[7:0]))))
    else $error("open load wrong address or byte");
  AST_IRQ_MASK: assert property (irq_mask_o == ((ivec_in_boot_i && !ex_boot && !lock_bits_o[3])
      || (!ivec_in_boot_i && ex_boot && !lock_bits_o[5])))
    else $error("interrupt mask wrong");
  AST_ERASE: assert property (chip_erase_i |=> lock_bits_o == 8'hff)
    else $error("chip erase did not clear locks");
  AST_LOCK_MONO: assert property (!chip_erase_i |=> (lock_bits_o & ~$past(lock_bits_o)) == 8'h00)
    else $error("lock bit returned to one without erase");
  AST_EXT_ABSENT: assert property (PROG_BYTES > 65536 || ptr_ext_o == 8'h00)
    else $error("pointer extension present in small space");

  cover property (store_go_o);
  cover property (store_refused_o);
  cover property (load_valid_o && load_blocked_o);
endmodule : fswp_monitor

/* bench/fswp_top_tb.sv */
/*
  Self-checking bench for fswp_top.
  Assumes the flash model and checker files compiled before it.
*/
`timescale 1ns/1ps
module fswp_top_tb;
  import fswp_pkg::*;
  localparam logic [23:0] APP_PC  = 24'h000100;
  localparam logic [23:0] BOOT_PC = 24'h007010;
  logic clk_sys_i, rst_i, ptr_ext_wr_i, ptr_hi_wr_i, ptr_lo_wr_i, ivec_in_boot_i, store_req_i, load_req_i;
  logic prog_lock_wr_i, prog_fuse_wr_i, prog_fuse_data_i, chip_erase_i, irq_mask_o, store_go_o, store_refused_o;
  logic load_busy_o, flash_rd_o, load_valid_o, load_blocked_o;
  logic [7:0]  ptr_wdata_i, prog_lock_data_i, ptr_ext_o, ptr_hi_o, ptr_lo_o, flash_word_o, load_data_o, lock_bits_o;
  logic [15:0] store_data_i, flash_page_o, flash_wdata_o, flash_rdata_i, reset_addr_o;
  logic [23:0] exec_pc_i;
  logic [22:0] flash_raddr_o;
  fswp_cmd_t   store_cmd_i, flash_cmd_o;
  fswp_prot_t  app_protection_mode_o, boot_protection_mode_o;
  int          failures, comparisons;

  fswp_top uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ptr_ext_wr_i(ptr_ext_wr_i), .ptr_hi_wr_i(ptr_hi_wr_i),
    .ptr_lo_wr_i(ptr_lo_wr_i), .ptr_wdata_i(ptr_wdata_i), .ptr_ext_o(ptr_ext_o), .ptr_hi_o(ptr_hi_o),
    .ptr_lo_o(ptr_lo_o), .exec_pc_i(exec_pc_i), .ivec_in_boot_i(ivec_in_boot_i), .irq_mask_o(irq_mask_o),
    .store_req_i(store_req_i), .store_cmd_i(store_cmd_i), .store_data_i(store_data_i), .store_go_o(store_go_o),
    .store_refused_o(store_refused_o), .flash_cmd_o(flash_cmd_o), .flash_page_o(flash_page_o),
    .flash_word_o(flash_word_o), .flash_wdata_o(flash_wdata_o), .load_req_i(load_req_i), .load_busy_o(load_busy_o),
    .flash_rd_o(flash_rd_o), .flash_raddr_o(flash_raddr_o), .flash_rdata_i(flash_rdata_i),
    .load_valid_o(load_valid_o), .load_blocked_o(load_blocked_o), .load_data_o(load_data_o),
    .prog_lock_wr_i(prog_lock_wr_i), .prog_lock_data_i(prog_lock_data_i), .prog_fuse_wr_i(prog_fuse_wr_i),
    .prog_fuse_data_i(prog_fuse_data_i), .chip_erase_i(chip_erase_i), .lock_bits_o(lock_bits_o),
    .reset_addr_o(reset_addr_o), .app_protection_mode_o(app_protection_mode_o),
    .boot_protection_mode_o(boot_protection_mode_o));
  fswp_flash_model flash_mdl (.clk_sys_i(clk_sys_i), .flash_rd_i(flash_rd_o), .flash_raddr_i(flash_raddr_o),
    .flash_rdata_o(flash_rdata_i));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick();
    @(posedge clk_sys_i);
    #2;
  endtask : tick

  task automatic chk(logic [23:0] seen, logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic set_ptr(logic [15:0] p);
    ptr_hi_wr_i = 1;
    ptr_wdata_i = p[15:8];
    tick();
    ptr_hi_wr_i = 0;
    ptr_lo_wr_i = 1;
    ptr_wdata_i = p[7:0];
    tick();
    ptr_lo_wr_i = 0;
  endtask : set_ptr

  task automatic set_lock(logic [7:0] b);
    chip_erase_i = 1;
    tick();
    chip_erase_i = 0;
    prog_lock_wr_i = 1;
    prog_lock_data_i = b;
    tick();
    prog_lock_wr_i = 0;
    tick();
    chk(24'(lock_bits_o), 24'(b | 8'hc0));
  endtask : set_lock

  task automatic store(fswp_cmd_t c, logic [23:0] pc, logic [15:0] p, logic [15:0] d, logic go, logic rf);
    set_ptr(p);
    store_cmd_i = c;
    exec_pc_i = pc;
    store_data_i = d;
    store_req_i = 1;
    tick();
    store_req_i = 0;
    chk({22'h0, store_go_o, store_refused_o}, {22'h0, go, rf});
    if (go) chk({flash_page_o, flash_word_o}, {8'h00, p[15:8], 1'b0, p[7:1]});
    if (go) chk(24'(flash_cmd_o), 24'(c));
    tick();
  endtask : store

  task automatic load(logic [23:0] pc, logic [15:0] p, logic blk);
    logic [7:0] b;
    b = p[0] ? (p[8:1] ^ 8'ha5) : p[8:1];
    set_ptr(p);
    exec_pc_i = pc;
    load_req_i = 1;
    tick();
    load_req_i = 0;
    chk(24'({flash_rd_o, load_busy_o}), 24'({!blk, 1'b1}));
    tick();
    chk({14'h0, load_valid_o, load_blocked_o, load_data_o}, {14'h0, 1'b1, blk, blk ? 8'h00 : b});
    tick();
  endtask : load

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sw_lock();
    chk({lock_bits_o, reset_addr_o}, 24'hff0000);
    store(FSWP_CMD_LOCK, BOOT_PC, 16'h0001, 16'h00f3, 0, 0);
    chk(24'(lock_bits_o), 24'hf3);
    store(FSWP_CMD_LOCK, BOOT_PC, 16'h0001, 16'h003f, 0, 0);
    store(FSWP_CMD_LOCK, APP_PC, 16'h0001, 16'h0000, 0, 1);
    chk(24'(lock_bits_o), 24'hf3);
  endtask : t_sw_lock

  task automatic t_modes();
    logic        hi, lo;
    logic [7:0]  lb;
    logic [15:0] tp;
    logic [23:0] own, far;
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        hi = m < 2;
        lo = m == 0 || m == 3;
        lb = 8'hff;
        lb[2 + 2 * s] = lo;
        lb[3 + 2 * s] = hi;
        tp = s ? 16'he102 : 16'h1234;
        own = s ? BOOT_PC : APP_PC;
        far = s ? APP_PC : BOOT_PC;
        set_lock(lb);
        chk(24'(s ? boot_protection_mode_o : app_protection_mode_o), 24'(m));
        store(FSWP_CMD_FILL, BOOT_PC, tp, 16'h1234, lo, !lo);
        load(far, tp, !hi);
        load(own, tp, 1'b0);
        ivec_in_boot_i = !s;
        tick();
        chk(24'(irq_mask_o), 24'(!hi));
        ivec_in_boot_i = s[0];
        tick();
        chk(24'(irq_mask_o), 24'h0);
      end
    end
  endtask : t_modes

  task automatic t_ptr();
    ptr_ext_wr_i = 1;
    ptr_wdata_i = 8'ha5;
    tick();
    ptr_ext_wr_i = 0;
    chk(24'(ptr_ext_o), 24'h0);
    store(FSWP_CMD_FILL, BOOT_PC, 16'he1fe, 16'hbeef, 1, 0);
    set_ptr(16'h0102);
    chk({ptr_ext_o, ptr_hi_o, ptr_lo_o}, 24'h000102);
    chk({flash_page_o, flash_word_o}, 24'h00e17f);
    chk(24'(flash_wdata_o), 24'hbeef);
  endtask : t_ptr

  task automatic t_refuse();
    fswp_cmd_t c;
    set_lock(8'hfc);
    store(FSWP_CMD_FILL, APP_PC, 16'h1234, 16'h1111, 0, 1);
    store(FSWP_CMD_FUSE, BOOT_PC, 16'h1234, 16'h0000, 0, 1);
    chk(24'(reset_addr_o), 24'h0);
    c = FSWP_CMD_FILL;
    repeat (3) begin
      store(c, BOOT_PC, 16'he1fe, 16'h2222, 1, 0);
      c = c.next();
    end
    load(APP_PC, 16'he103, 0);
    prog_fuse_wr_i = 1;
    prog_fuse_data_i = 0;
    tick();
    prog_fuse_wr_i = 0;
    tick();
    chk(24'(reset_addr_o), 24'h007000);
  endtask : t_refuse

  initial begin
    clk_sys_i = 0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial begin
    {ptr_ext_wr_i, ptr_hi_wr_i, ptr_lo_wr_i, ivec_in_boot_i, store_req_i, load_req_i} = 6'h00;
    {prog_lock_wr_i, prog_fuse_wr_i, chip_erase_i} = 3'h0;
    rst_i = 1;
    prog_fuse_data_i = 1;
    ptr_wdata_i = 8'h00;
    prog_lock_data_i = 8'hff;
    store_data_i = 16'h0000;
    exec_pc_i = APP_PC;
    store_cmd_i = FSWP_CMD_FILL;
    repeat (20) tick();
    rst_i = 0;
    t_sw_lock();
    t_modes();
    t_ptr();
    t_refuse();
    report_and_stop();
  end
endmodule : fswp_top_tb

bind fswp_top fswp_monitor #(.PROG_BYTES(PROG_BYTES), .PAGE_WORDS(PAGE_WORDS), .BOOT_START_W(BOOT_START_W)) mon (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ptr_ext_o(ptr_ext_o), .ptr_hi_o(ptr_hi_o), .ptr_lo_o(ptr_lo_o),
  .exec_pc_i(exec_pc_i), .ivec_in_boot_i(ivec_in_boot_i), .irq_mask_o(irq_mask_o), .store_req_i(store_req_i),
  .store_cmd_i(store_cmd_i), .store_go_o(store_go_o), .store_refused_o(store_refused_o),
  .flash_page_o(flash_page_o), .flash_word_o(flash_word_o), .load_req_i(load_req_i), .load_busy_o(load_busy_o),
  .flash_rd_o(flash_rd_o), .flash_raddr_o(flash_raddr_o), .flash_rdata_i(flash_rdata_i),
  .load_valid_o(load_valid_o), .load_blocked_o(load_blocked_o), .load_data_o(load_data_o),
  .chip_erase_i(chip_erase_i), .lock_bits_o(lock_bits_o));
